// ===== design/spm_pkg.sv
// constants shared by the servo parameter and monitor bank
// assumes a 10 MHz clock and word-aligned Avalon-MM byte addresses
`default_nettype none
package spm_pkg;
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_MASK = 8'hD1;
   localparam logic [7:0] IDX_DATE = 8'hF0;
   localparam logic [7:0] IDX_TIME = 8'hF1;
   localparam logic [7:0] IDX_MINUTES = 8'hF2;
   localparam logic [7:0] IDX_ANALOG = 8'hF6;
   localparam logic [7:0] IDX_ICMD = 8'hF7;
   localparam logic [7:0] IDX_SPDCMD = 8'hF8;
   localparam logic [7:0] IDX_POSCMD = 8'hF9;
   localparam logic [7:0] IDX_IQ = 8'hFA;
   localparam logic [7:0] IDX_SPD = 8'hFB;
   localparam logic [7:0] IDX_POSERR = 8'hFC;
   // field layouts and values after reset
   localparam logic [15:0] MASK_IMPL = 16'h11FF;
   localparam logic [15:0] MASK_RST = 16'h0000;
   localparam logic [7:0] WRITE_KEY = 8'h88;
   localparam logic [23:0] DATE_RST = 24'h010101;
   localparam logic [23:0] TIME_RST = 24'h000000;
   localparam logic [31:0] MINUTES_MAX = 32'h77359400;
   localparam logic [15:0] MON16_MAX = 16'h7FFF;
   localparam logic [15:0] MON16_NEG = 16'h8001;
   // avalon answers
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int SEC_NS = 1000000000;
   localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
   localparam logic [5:0] SEC_LAST = 6'h3B;
   // bus handshake states
   typedef enum logic [1:0] {
      BUS_WAIT = 2'b01,
      BUS_ACK = 2'b10
   } spm_bus_e;
   // bcd byte plus one
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         return {v[7:4] + 4'h1, 4'h0};
      end
      return {v[7:4], v[3:0] + 4'h1};
   endfunction
   // bcd byte well formed and within lo..hi
   function automatic logic bcd_ok(input logic [7:0] v, input logic [7:0] lo,
                                   input logic [7:0] hi);
      return (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
   endfunction
   // last day of month in bcd, leap every fourth year
   function automatic logic [7:0] month_end(input logic [7:0] y, input logic [7:0] m);
      logic [7:0] yb;
      yb = {1'b0, y[7:4], 3'h0} + {3'h0, y[7:4], 1'b0} + {4'h0, y[3:0]};
      if (m == 8'h02) begin
         return (yb[1:0] == 2'h0) ? 8'h29 : 8'h28;
      end
      if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
         return 8'h30;
      end
      return 8'h31;
   endfunction
   function automatic logic date_ok(input logic [23:0] d);
      return bcd_ok(d[23:16], 8'h01, 8'h99) && bcd_ok(d[15:8], 8'h01, 8'h12) &&
             bcd_ok(d[7:0], 8'h01, month_end(d[23:16], d[15:8]));
   endfunction
   function automatic logic time_ok(input logic [23:0] t);
      return bcd_ok(t[23:16], 8'h00, 8'h23) && bcd_ok(t[15:8], 8'h00, 8'h59) &&
             bcd_ok(t[7:0], 8'h00, 8'h59);
   endfunction
   // clamp the one code outside the symmetric +-32767 scale
   function automatic logic [15:0] sym16(input logic [15:0] v);
      return (v == 16'h8000) ? MON16_NEG : v;
   endfunction
endpackage : spm_pkg
`default_nettype wire

// ===== design/spm_bank.sv
// parameter bank: alarm mask, BCD calendar, power-on minutes, monitors
// assumes monitor inputs are already scaled and synchronous to clock_i
`default_nettype none
module spm_bank
   import spm_pkg::*;
#(
   parameter int SEC_CYCLES_P = SEC_CYCLES
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [9:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [1:0] avs_response_o,
   input wire logic [15:0] alarm_detect_i,
   output logic [15:0] alarm_issue_o,
   output logic hist_wr_o,
   output logic [7:0] hist_code_o,
   output logic [23:0] hist_date_o,
   output logic [23:0] hist_time_o,
   input wire logic [23:0] retain_date_i,
   input wire logic [23:0] retain_time_i,
   output logic retain_wr_o,
   output logic [23:0] retain_date_o,
   output logic [23:0] retain_time_o,
   input wire logic [31:0] nv_minutes_i,
   input wire logic power_fail_i,
   output logic nv_save_o,
   output logic [31:0] nv_minutes_o,
   input wire logic [15:0] mon_analog_i,
   input wire logic [15:0] mon_icmd_i,
   input wire logic [15:0] mon_spdcmd_i,
   input wire logic [31:0] mon_poscmd_i,
   input wire logic [15:0] mon_iq_i,
   input wire logic [15:0] mon_spd_i,
   input wire logic [31:0] mon_poserr_i
);
   spm_bus_e bus_q;
   logic [31:0] rdata_q;
   logic [1:0] resp_q;
   logic [15:0] mask_q;
   logic [23:0] date_q, date_nx;
   logic [23:0] time_q, time_nx;
   logic day_roll;
   logic [23:0] sec_cnt_q;
   logic sec_tick;
   logic [5:0] pwr_sec_q;
   logic [31:0] minutes_q;
   logic boot_q;
   logic pf_q;
   logic [15:0] issue_d, issue_q, fresh;
   logic hist_wr_q, retain_wr_q, nv_save_q;
   logic [7:0] hist_code_q;
   logic [23:0] hist_date_q, hist_time_q;
   logic [31:0] nv_min_q;
   logic [15:0] analog_q, icmd_q, spdcmd_q, iq_q, spd_q;
   logic [31:0] poscmd_q, poserr_q;
   logic [7:0] idx;
   logic take_rd, take_wr, wr_full, key_ok;
   logic wr_date, wr_time;
   logic [31:0] rd_mux;
   logic rd_hit;

   assign idx = avs_address_i[9:2];
   assign take_rd = (bus_q == BUS_WAIT) && avs_read_i;
   assign take_wr = (bus_q == BUS_ACK) && avs_write_i;
   assign wr_full = (avs_byteenable_i == 4'hF);
   assign key_ok = wr_full && (avs_writedata_i[31:24] == WRITE_KEY);
   // keyed, fully formed date and time writes only
   assign wr_date = take_wr && idx == IDX_DATE && key_ok &&
                    date_ok(avs_writedata_i[23:0]);
   assign wr_time = take_wr && idx == IDX_TIME && key_ok &&
                    time_ok(avs_writedata_i[23:0]);

   // handshake: one wait cycle, then waitrequest low for the transfer edge
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         bus_q <= BUS_WAIT;
      end else if (bus_q == BUS_WAIT && (avs_read_i || avs_write_i)) begin
         bus_q <= BUS_ACK;
      end else begin
         bus_q <= BUS_WAIT;
      end
   end
   assign avs_waitrequest_o = bus_q[0];

   // read mux, upper bits of narrow registers read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (idx)
         IDX_MASK: rd_mux = {16'h0000, mask_q};
         IDX_DATE: rd_mux = {8'h00, date_q};
         IDX_TIME: rd_mux = {8'h00, time_q};
         IDX_MINUTES: rd_mux = minutes_q;
         IDX_ANALOG: rd_mux = {16'h0000, analog_q};
         IDX_ICMD: rd_mux = {16'h0000, icmd_q};
         IDX_SPDCMD: rd_mux = {16'h0000, spdcmd_q};
         IDX_POSCMD: rd_mux = poscmd_q;
         IDX_IQ: rd_mux = {16'h0000, iq_q};
         IDX_SPD: rd_mux = {16'h0000, spd_q};
         IDX_POSERR: rd_mux = poserr_q;
         default: rd_hit = 1'b0;
      endcase
   end

   // read data and answer captured while waitrequest is still high
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rdata_q <= 32'h0000_0000;
         resp_q <= RESP_OK;
      end else if (bus_q == BUS_WAIT && (avs_read_i || avs_write_i)) begin
         rdata_q <= (take_rd && rd_hit) ? rd_mux : 32'h0000_0000;
         resp_q <= rd_hit ? RESP_OK : RESP_DECERR;
      end
   end
   assign avs_readdata_o = rdata_q;
   assign avs_response_o = resp_q;

   // alarm mask, only implemented bits stored, reserved read zero
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         mask_q <= MASK_RST;
      end else if (take_wr && idx == IDX_MASK) begin
         if (avs_byteenable_i[0]) begin
            mask_q[7:0] <= avs_writedata_i[7:0];
         end
         if (avs_byteenable_i[1]) begin
            mask_q[15:8] <= avs_writedata_i[15:8] & MASK_IMPL[15:8];
         end
      end
   end

   // alarm gating by mask
   assign issue_d = alarm_detect_i & ~mask_q & MASK_IMPL;
   assign fresh = issue_d & ~issue_q;
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         issue_q <= 16'h0000;
      end else begin
         issue_q <= issue_d;
      end
   end
   assign alarm_issue_o = issue_q;

   // alarm history entry stamped with the present calendar
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         hist_wr_q <= 1'b0;
         hist_code_q <= 8'h00;
         hist_date_q <= DATE_RST;
         hist_time_q <= TIME_RST;
      end else begin
         hist_wr_q <= (fresh != 16'h0000);
         if (fresh != 16'h0000) begin
            hist_date_q <= date_q;
            hist_time_q <= time_q;
            hist_code_q <= fresh[0] ? 8'h21 : fresh[1] ? 8'h22 : fresh[2] ? 8'h31 :
                           fresh[3] ? 8'h41 : fresh[4] ? 8'h42 : fresh[5] ? 8'h51 :
                           fresh[6] ? 8'h67 : fresh[7] ? 8'h68 : fresh[8] ? 8'h74 : 8'h72;
         end
      end
   end
   assign hist_wr_o = hist_wr_q;
   assign hist_code_o = hist_code_q;
   assign hist_date_o = hist_date_q;
   assign hist_time_o = hist_time_q;

   // one-second enable, restarted by a time write
   assign sec_tick = (sec_cnt_q == 24'(SEC_CYCLES_P - 1));
   always_ff @(posedge clock_i) begin
      if (rst_i || sec_tick || wr_time) begin
         sec_cnt_q <= 24'h000000;
      end else begin
         sec_cnt_q <= sec_cnt_q + 24'h000001;
      end
   end

   // next time of day and date on a second tick
   always_comb begin
      time_nx = time_q;
      date_nx = date_q;
      day_roll = 1'b0;
      if (time_q[7:0] != 8'h59) begin
         time_nx[7:0] = bcd_inc(time_q[7:0]);
      end else begin
         time_nx[7:0] = 8'h00;
         if (time_q[15:8] != 8'h59) begin
            time_nx[15:8] = bcd_inc(time_q[15:8]);
         end else begin
            time_nx[15:8] = 8'h00;
            if (time_q[23:16] != 8'h23) begin
               time_nx[23:16] = bcd_inc(time_q[23:16]);
            end else begin
               time_nx[23:16] = 8'h00;
               day_roll = 1'b1;
            end
         end
      end
      if (day_roll) begin
         if (date_q[7:0] != month_end(date_q[23:16], date_q[15:8])) begin
            date_nx[7:0] = bcd_inc(date_q[7:0]);
         end else begin
            date_nx[7:0] = 8'h01;
            if (date_q[15:8] != 8'h12) begin
               date_nx[15:8] = bcd_inc(date_q[15:8]);
            end else begin
               date_nx[15:8] = 8'h01;
               // year wraps to 01, never to 00
               date_nx[23:16] = (date_q[23:16] == 8'h99) ? 8'h01 : bcd_inc(date_q[23:16]);
            end
         end
      end
   end

   // boot flag: retained values are loaded in the cycle after reset
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         boot_q <= 1'b1;
      end else begin
         boot_q <= 1'b0;
      end
   end

   // calendar registers; a host write beats the tick
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         date_q <= DATE_RST;
         time_q <= TIME_RST;
      end else if (boot_q) begin
         date_q <= date_ok(retain_date_i) ? retain_date_i : DATE_RST;
         time_q <= time_ok(retain_time_i) ? retain_time_i : TIME_RST;
      end else begin
         if (wr_date) begin
            date_q <= avs_writedata_i[23:0];
         end else if (sec_tick) begin
            date_q <= date_nx;
         end
         if (wr_time) begin
            time_q <= avs_writedata_i[23:0];
         end else if (sec_tick) begin
            time_q <= time_nx;
         end
      end
   end

   // retained storage strobe, the cycle after any calendar change except the boot load
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         retain_wr_q <= 1'b0;
      end else begin
         retain_wr_q <= !boot_q && (wr_date || wr_time || sec_tick);
      end
   end
   assign retain_wr_o = retain_wr_q;
   assign retain_date_o = date_q;
   assign retain_time_o = time_q;

   // powered minutes: partial minute lives only in pwr_sec_q
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pwr_sec_q <= 6'h00;
         minutes_q <= 32'h0000_0000;
      end else if (boot_q) begin
         pwr_sec_q <= 6'h00;
         minutes_q <= (nv_minutes_i > MINUTES_MAX) ? MINUTES_MAX : nv_minutes_i;
      end else if (sec_tick) begin
         if (pwr_sec_q == SEC_LAST) begin
            pwr_sec_q <= 6'h00;
            if (minutes_q != MINUTES_MAX) begin
               minutes_q <= minutes_q + 32'h0000_0001;
            end
         end else begin
            pwr_sec_q <= pwr_sec_q + 6'h01;
         end
      end
   end

   // save whole minutes when power fails
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pf_q <= 1'b0;
         nv_save_q <= 1'b0;
         nv_min_q <= 32'h0000_0000;
      end else begin
         pf_q <= power_fail_i;
         nv_save_q <= power_fail_i && !pf_q;
         if (power_fail_i && !pf_q) begin
            nv_min_q <= minutes_q;
         end
      end
   end
   assign nv_save_o = nv_save_q;
   assign nv_minutes_o = nv_min_q;

   // live monitors, never written by the host
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         analog_q <= 16'h0000;
         icmd_q <= 16'h0000;
         spdcmd_q <= 16'h0000;
         iq_q <= 16'h0000;
         spd_q <= 16'h0000;
         poscmd_q <= 32'h0000_0000;
         poserr_q <= 32'h0000_0000;
      end else begin
         analog_q <= sym16(mon_analog_i);
         icmd_q <= mon_icmd_i;
         spdcmd_q <= sym16(mon_spdcmd_i);
         iq_q <= mon_iq_i;
         spd_q <= sym16(mon_spd_i);
         poscmd_q <= mon_poscmd_i;
         poserr_q <= mon_poserr_i;
      end
   end

   // checks
   sequence s_key_time;
      take_wr && idx == IDX_TIME && key_ok && time_ok(avs_writedata_i[23:0]);
   endsequence
   sequence s_pf_rise;
      power_fail_i && !pf_q;
   endsequence

   a_mask_gating: assert property (@(posedge clock_i) disable iff (rst_i)
      !$past(rst_i) |-> alarm_issue_o == ($past(alarm_detect_i) & ~$past(mask_q) & MASK_IMPL))
      else $error("issued alarms differ from masked detections");
   a_mask_low: assert property (@(posedge clock_i) disable iff (rst_i)
      mask_q[0] && mask_q[1] |=> alarm_issue_o[1:0] == 2'h0)
      else $error("masked overload alarm issued");
   a_mask_mid: assert property (@(posedge clock_i) disable iff (rst_i)
      alarm_detect_i[4:2] == 3'h7 && mask_q[4:2] == 3'h0 |=> alarm_issue_o[4:2] == 3'h7)
      else $error("unmasked speed or position alarm lost");
   a_mask_upper: assert property (@(posedge clock_i) disable iff (rst_i)
      mask_q[7:5] == 3'h7 |=> alarm_issue_o[7:5] == 3'h0)
      else $error("masked temperature or encoder alarm issued");
   a_mask_power: assert property (@(posedge clock_i) disable iff (rst_i)
      mask_q[8] && mask_q[12] |=> !alarm_issue_o[8] && !alarm_issue_o[12])
      else $error("masked regeneration or power alarm issued");
   a_reserved_zero: assert property (@(posedge clock_i) disable iff (rst_i)
      alarm_issue_o[15:13] == 3'h0 && alarm_issue_o[11:9] == 3'h0)
      else $error("alarm issued on reserved position");
   a_date_valid: assert property (@(posedge clock_i) disable iff (rst_i)
      !boot_q |-> date_ok(date_q) && date_q[23:16] != 8'h00)
      else $error("calendar date out of range");
   a_date_read: assert property (@(posedge clock_i) disable iff (rst_i)
      take_rd && idx == IDX_DATE && !sec_tick |=> avs_readdata_o == {8'h00, date_q})
      else $error("date read mismatch");
   a_time_valid: assert property (@(posedge clock_i) disable iff (rst_i)
      time_q <= 24'h235959 && time_ok(time_q))
      else $error("time of day out of range");
   a_time_store: assert property (@(posedge clock_i) disable iff (rst_i)
      s_key_time |=> time_q == $past(avs_writedata_i[23:0]) ##0 retain_wr_o)
      else $error("keyed time write not stored");
   a_unkeyed_time: assert property (@(posedge clock_i) disable iff (rst_i)
      take_wr && idx == IDX_TIME && !key_ok && !sec_tick |=> $stable(time_q))
      else $error("time changed without key");
   a_commit_now: assert property (@(posedge clock_i) disable iff (rst_i)
      wr_date |=> retain_wr_o && retain_date_o == $past(avs_writedata_i[23:0]))
      else $error("date write not committed");
   a_hist_stamp: assert property (@(posedge clock_i) disable iff (rst_i)
      fresh != 16'h0000 |=> hist_wr_o && hist_time_o == $past(time_q) &&
      hist_date_o == $past(date_q))
      else $error("alarm history stamp wrong");
   a_minutes_cap: assert property (@(posedge clock_i) disable iff (rst_i)
      minutes_q <= MINUTES_MAX)
      else $error("powered minutes above limit");
   a_minute_step: assert property (@(posedge clock_i) disable iff (rst_i || boot_q)
      !$past(boot_q) && minutes_q != $past(minutes_q) |->
      minutes_q == $past(minutes_q) + 32'h0000_0001)
      else $error("powered minutes stepped wrongly");
   a_power_save: assert property (@(posedge clock_i) disable iff (rst_i)
      s_pf_rise |=> nv_save_o && nv_minutes_o == $past(minutes_q) ##1 !nv_save_o)
      else $error("power-off save wrong");
   a_speed_sym: assert property (@(posedge clock_i) disable iff (rst_i)
      spd_q != 16'h8000 && spdcmd_q != 16'h8000 && analog_q != 16'h8000)
      else $error("monitor outside symmetric scale");
   a_ro_ignored: assert property (@(posedge clock_i) disable iff (rst_i)
      take_wr && idx == IDX_MINUTES && !sec_tick |=> $stable(minutes_q))
      else $error("write reached read-only counter");
endmodule // spm_bank
`default_nettype wire

// ===== bench/spm_nv_model.sv
// nonvolatile store model: retained calendar and saved power-on minutes
// assumes the save strobes are one-cycle pulses from the bank
`default_nettype none
module spm_nv_model (
   input wire logic clock_i,
   input wire logic retain_wr_i,
   input wire logic [23:0] date_i,
   input wire logic [23:0] time_i,
   input wire logic nv_save_i,
   input wire logic [31:0] minutes_i,
   output logic [23:0] date_o,
   output logic [23:0] time_o,
   output logic [31:0] minutes_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // contents found at power-up
   initial begin
      date_o = 24'h240305;
      time_o = 24'h100000;
      minutes_o = 32'h00001E78;
   end
   // commit on each strobe from the bank
   always @(posedge clock_i) begin
      if (retain_wr_i) begin
         date_o <= date_i;
         time_o <= time_i;
      end
      if (nv_save_i) begin
         minutes_o <= minutes_i;
      end
   end
endmodule // spm_nv_model
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the servo parameter bank
// assumes a one-wait-state Avalon slave and a 20-cycle second tick
`default_nettype none
module tb_top;
   import spm_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic [9:0] avs_address_i = 10'h000;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o, nv_minutes_o, nv_min, rd_v;
   logic avs_waitrequest_o, hist_wr_o, retain_wr_o, nv_save_o;
   logic [1:0] avs_response_o, rsp_v;
   logic [15:0] alarm_detect_i = 16'h0;
   logic [15:0] alarm_issue_o;
   logic [7:0] hist_code_o;
   logic [23:0] hist_date_o, hist_time_o, retain_date_o, retain_time_o, nv_date, nv_time;
   logic power_fail_i = 1'b0;
   logic [3:0] avs_byteenable_i = 4'hF;
   // monitor levels seen by the bank
   logic [15:0] mon_analog_i = 16'h8000, mon_icmd_i = 16'h4000, mon_spdcmd_i = 16'h7FFF;
   logic [15:0] mon_iq_i = 16'hC000, mon_spd_i = 16'h8000;
   logic [31:0] mon_poscmd_i = 32'h80000001, mon_poserr_i = 32'h12345678;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int bitpos [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 12};
   logic [7:0] codes [10] = '{8'h21, 8'h22, 8'h31, 8'h41, 8'h42, 8'h51, 8'h67, 8'h68,
      8'h74, 8'h72};
   logic [7:0] mon_idx [7] = '{IDX_ANALOG, IDX_ICMD, IDX_SPDCMD, IDX_POSCMD, IDX_IQ,
      IDX_SPD, IDX_POSERR};
   logic [31:0] mon_exp [7] = '{32'h00008001, 32'h00004000, 32'h00007FFF, 32'h80000001,
      32'h0000C000, 32'h00008001, 32'h12345678};

   spm_bank #(.SEC_CYCLES_P(20)) dut_u (.clock_i(clock_i), .rst_i(rst_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .avs_response_o(avs_response_o), .alarm_detect_i(alarm_detect_i),
      .alarm_issue_o(alarm_issue_o), .hist_wr_o(hist_wr_o), .hist_code_o(hist_code_o),
      .hist_date_o(hist_date_o), .hist_time_o(hist_time_o), .retain_date_i(nv_date),
      .retain_time_i(nv_time), .retain_wr_o(retain_wr_o), .retain_date_o(retain_date_o),
      .retain_time_o(retain_time_o), .nv_minutes_i(nv_min), .power_fail_i(power_fail_i),
      .nv_save_o(nv_save_o), .nv_minutes_o(nv_minutes_o), .mon_analog_i(mon_analog_i),
      .mon_icmd_i(mon_icmd_i), .mon_spdcmd_i(mon_spdcmd_i), .mon_poscmd_i(mon_poscmd_i),
      .mon_iq_i(mon_iq_i), .mon_spd_i(mon_spd_i), .mon_poserr_i(mon_poserr_i));

   spm_nv_model nv_u (.clock_i(clock_i), .retain_wr_i(retain_wr_o), .date_i(retain_date_o),
      .time_i(retain_time_o), .nv_save_i(nv_save_o), .minutes_i(nv_minutes_o),
      .date_o(nv_date), .time_o(nv_time), .minutes_o(nv_min));

   // clock and cycle count
   always #50 clock_i = ~clock_i;
   always @(posedge clock_i) cyc <= cyc + 1;

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      avs_address_i <= {idx, 2'b00};
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      avs_writedata_i <= wd;
      // no cycle limit here, a hang is left to the watchdog
      do begin
         @(posedge clock_i);
      end while (avs_waitrequest_o !== 1'b0);
      rd_v = avs_readdata_o;
      rsp_v = avs_response_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clock_i);
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0);
      chk(rd_v, exp);
      chk(rsp_v, RESP_OK);
   endtask

   // hang guard
   initial begin
      repeat (20000) @(posedge clock_i);
      n_errors++;
      test_done;
   end

   // main sequence
   initial begin
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      rdc(IDX_MASK, 32'h0);
      rdc(IDX_DATE, 32'h00240305);
      rdc(IDX_MINUTES, 32'h00001E78);
      // power-off well inside the first minute
      power_fail_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      chk(nv_save_o, 1'b1);
      chk(nv_minutes_o, 32'h00001E78);
      power_fail_i <= 1'b0;
      // every alarm alone with the mask clear
      for (int i = 0; i < 10; i++) begin
         alarm_detect_i <= 16'h1 << bitpos[i];
         repeat (2) @(posedge clock_i);
         chk(alarm_issue_o, 16'h1 << bitpos[i]);
         chk(hist_wr_o, 1'b1);
         chk(hist_code_o, codes[i]);
         chk(hist_date_o, 24'h240305);
         alarm_detect_i <= 16'h0;
         repeat (2) @(posedge clock_i);
      end
      bus(1'b1, IDX_MASK, 32'h000011FF);
      rdc(IDX_MASK, 32'h000011FF);
      alarm_detect_i <= 16'hFFFF;
      repeat (2) @(posedge clock_i);
      chk(alarm_issue_o, 16'h0);
      chk(hist_wr_o, 1'b0);
      alarm_detect_i <= 16'h0;
      // low byte only, the upper mask byte keeps 0x11
      avs_byteenable_i <= 4'h1;
      bus(1'b1, IDX_MASK, 32'h00000021);
      avs_byteenable_i <= 4'hF;
      rdc(IDX_MASK, 32'h00001121);
      alarm_detect_i <= 16'h11FF;
      repeat (2) @(posedge clock_i);
      chk(alarm_issue_o, 16'h00DE);
      chk(hist_code_o, 8'h22);
      alarm_detect_i <= 16'h0;
      // monitors read live and ignore writes
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, mon_idx[i], 32'hFFFFFFFF);
         rdc(mon_idx[i], mon_exp[i]);
      end
      bus(1'b1, IDX_MINUTES, 32'h0);
      bus(1'b0, 8'h00, 32'h0);
      chk(rsp_v, RESP_DECERR);
      chk(rd_v, 32'h0);
      // one whole minute has passed by now
      wait (cyc >= 1300);
      @(posedge clock_i);
      rdc(IDX_MINUTES, 32'h00001E79);
      // keyed calendar writes
      bus(1'b1, IDX_TIME, 32'h88113201);
      rdc(IDX_TIME, 32'h00113201);
      chk(nv_time, 24'h113201);
      bus(1'b1, IDX_TIME, 32'h00123456);
      rdc(IDX_TIME, 32'h00113201);
      bus(1'b1, IDX_DATE, 32'h88991231);
      rdc(IDX_DATE, 32'h00991231);
      chk(nv_date, 24'h991231);
      bus(1'b1, IDX_DATE, 32'h88000305);
      rdc(IDX_DATE, 32'h00991231);
      test_done;
   end
endmodule // tb_top
`default_nettype wire
